// >>> sep_device.sv
// eeprom slave end: address match, ack polling, write protect, pointer reads
`timescale 1ns/100ps
`default_nettype none
module sep_device #(
  parameter int         MEM_ADDR_W   = 8,              // array address width, at most 16
  parameter logic [3:0] DEV_ID       = sep_pkg::DEV_ID, // identifier nibble
  parameter int         WRITE_CYCLES = sep_pkg::WRITE_TIME_NS / sep_pkg::LINK_PERIOD_NS // write cycle length
) (
  input  wire logic link_clk,            // link sampling clock
  input  wire logic rst,                 // synchronous reset, link_clk domain
  input  wire logic wp,                  // write protect pin
  input  wire logic address_select_bit0, // address select pin 0
  input  wire logic address_select_bit1, // address select pin 1
  input  wire logic address_select_bit2, // address select pin 2
  sep_if.dev        bus,                 // two-wire link
  output logic      write_busy           // internal write cycle running
);
  localparam int HOLD_CYC = (sep_pkg::OUT_HOLD_NS + sep_pkg::LINK_PERIOD_NS - 1) / sep_pkg::LINK_PERIOD_NS;
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(1);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES);
  localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(1);

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
    return b[7:1] == {DEV_ID, sel};
  endfunction

  logic                    scl_meta;
  logic                    scl_sync;
  logic                    sda_meta;
  logic                    sda_sync;
  logic                    wp_meta;
  logic                    wp_sync;
  logic [2:0]              sel_meta;
  logic [2:0]              sel_sync;
  logic                    scl_q;
  logic                    sda_q;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  sep_pkg::sep_dev_state_t state;
  sep_pkg::sep_rx_kind_t   kind;
  logic [3:0]              bit_cnt;
  logic [7:0]              rx_sh;
  logic [7:0]              tx_sh;
  logic [7:0]              addr_hi;
  logic [15:0]             full_addr;
  logic                    rw;
  logic                    wrote;
  logic                    launch;
  logic                    sched;
  logic                    sched_val;
  logic                    drive_next;
  logic [HOLD_W-1:0]       hold_cnt;
  logic [BUSY_W-1:0]       busy_cnt;
  logic [MEM_ADDR_W-1:0]   ptr;
  logic [7:0]              mem [2**MEM_ADDR_W];

  // pins and link lines are asynchronous to link_clk
  always_ff @(posedge link_clk) begin
    scl_meta <= bus.scl;
    scl_sync <= scl_meta;
    sda_meta <= bus.sda;
    sda_sync <= sda_meta;
    wp_meta <= wp;
    wp_sync <= wp_meta;
    sel_meta <= {address_select_bit2, address_select_bit1, address_select_bit0};
    sel_sync <= sel_meta;
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_sync;
      sda_q <= sda_sync;
    end
  end

  assign scl_rise = scl_sync & ~scl_q;
  assign scl_fall = ~scl_sync & scl_q;
  assign start_det = scl_sync & scl_q & sda_q & ~sda_sync;
  assign stop_det = scl_sync & scl_q & ~sda_q & sda_sync;
  assign full_addr = {addr_hi, rx_sh};

  // protocol engine; sched asks the output stage to change the data line later
  always_ff @(posedge link_clk) begin
    if (rst) begin
      state <= sep_pkg::D_IDLE;
      kind <= sep_pkg::K_SLAVE;
      bit_cnt <= '0;
      rx_sh <= '0;
      tx_sh <= '0;
      addr_hi <= '0;
      rw <= sep_pkg::RW_WRITE;
      wrote <= 1'b0;
      launch <= 1'b0;
      sched <= 1'b0;
      sched_val <= 1'b0;
      ptr <= '0;
    end else begin
      sched <= 1'b0;
      launch <= 1'b0;
      if (stop_det) begin
        state <= sep_pkg::D_IDLE;
        wrote <= 1'b0;
        launch <= wrote;
      end else if (start_det) begin
        state <= sep_pkg::D_RX;
        kind <= sep_pkg::K_SLAVE;
        bit_cnt <= '0;
      end else begin
        case (state)
          sep_pkg::D_RX: begin
            if (scl_rise) begin
              rx_sh <= {rx_sh[6:0], sda_sync};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall && bit_cnt == sep_pkg::BIT_ACK) begin
              sched <= 1'b1;
              sched_val <= 1'b1;
              state <= sep_pkg::D_RX_ACK;
              case (kind)
                sep_pkg::K_SLAVE: begin
                  // an address byte seen while busy gets no ack at all
                  if (addr_match(rx_sh, sel_sync) && !write_busy) begin
                    rw <= rx_sh[0];
                  end else begin
                    sched <= 1'b0;
                    state <= sep_pkg::D_IDLE;
                  end
                end
                sep_pkg::K_HI: begin
                  addr_hi <= rx_sh;
                end
                sep_pkg::K_LO: begin
                  ptr <= full_addr[MEM_ADDR_W-1:0];
                end
                sep_pkg::K_DATA: begin
                  if (wp_sync) begin
                    sched <= 1'b0;
                    state <= sep_pkg::D_WAIT_STOP;
                  end else begin
                    mem[ptr] <= rx_sh;
                    ptr <= ptr + 1'b1;
                    wrote <= 1'b1;
                  end
                end
                default: begin
                  state <= sep_pkg::D_IDLE;
                end
              endcase
            end
          end
          sep_pkg::D_RX_ACK: begin
            if (scl_fall) begin
              bit_cnt <= '0;
              sched <= 1'b1;
              if (kind == sep_pkg::K_SLAVE && rw == sep_pkg::RW_READ) begin
                tx_sh <= mem[ptr];
                ptr <= ptr + 1'b1;
                sched_val <= ~mem[ptr][7];
                state <= sep_pkg::D_TX;
              end else begin
                sched_val <= 1'b0;
                state <= sep_pkg::D_RX;
                if (kind != sep_pkg::K_DATA) begin
                  kind <= sep_pkg::sep_rx_kind_t'(kind + 2'b01);
                end
              end
            end
          end
          sep_pkg::D_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall) begin
              sched <= 1'b1;
              if (bit_cnt == sep_pkg::BIT_ACK) begin
                sched_val <= 1'b0;
                state <= sep_pkg::D_TX_ACK;
              end else begin
                tx_sh <= {tx_sh[6:0], 1'b0};
                sched_val <= ~tx_sh[6];
              end
            end
          end
          sep_pkg::D_TX_ACK: begin
            if (scl_rise) begin
              if (sda_sync) begin
                state <= sep_pkg::D_WAIT_STOP;
              end else begin
                tx_sh <= mem[ptr];
                ptr <= ptr + 1'b1;
              end
            end else if (scl_fall) begin
              bit_cnt <= '0;
              sched <= 1'b1;
              sched_val <= ~tx_sh[7];
              state <= sep_pkg::D_TX;
            end
          end
          sep_pkg::D_WAIT_STOP: begin
            state <= sep_pkg::D_WAIT_STOP;
          end
          default: begin
            state <= sep_pkg::D_IDLE;
          end
        endcase
      end
    end
  end

  // output stage: each scheduled change waits out the hold so scl low is settled first; start and stop release at once
  always_ff @(posedge link_clk) begin
    if (rst || start_det || stop_det) begin
      bus.sda_s_o <= 1'b0;
      bus.sda_s_oe <= 1'b0;
      hold_cnt <= '0;
      drive_next <= 1'b0;
    end else if (sched) begin
      hold_cnt <= HOLD_LOAD;
      drive_next <= sched_val;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
      if (hold_cnt == HOLD_LAST) begin
        bus.sda_s_oe <= drive_next;
      end
    end
  end

  // internal write cycle timer; the array itself is updated at once
  always_ff @(posedge link_clk) begin
    if (rst) begin
      write_busy <= 1'b0;
      busy_cnt <= '0;
    end else if (launch) begin
      write_busy <= 1'b1;
      busy_cnt <= BUSY_LOAD;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - 1'b1;
      if (busy_cnt == BUSY_LAST) begin
        write_busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sep_pkg.sv
// shared constants and types for the serial eeprom link ends
package sep_pkg;
  localparam logic [3:0] DEV_ID = 4'h5; // arbitrary identifier value, not a real maker code
  localparam logic       RW_READ = 1'b1;
  localparam logic       RW_WRITE = 1'b0;
  localparam logic [3:0] BIT_ACK = 4'h8; // bit index of the acknowledge slot
  localparam int         LINK_PERIOD_NS = 32;
  localparam int         OUT_HOLD_NS = 300;
  localparam int         WRITE_TIME_NS = 5000000;
  localparam int         CLOCK_PERIOD_NS = 4;
  localparam int         SCL_PERIOD_NS = 10000;
  localparam int         FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    D_IDLE      = 3'b000,
    D_RX        = 3'b001,
    D_RX_ACK    = 3'b010,
    D_TX        = 3'b011,
    D_TX_ACK    = 3'b100,
    D_WAIT_STOP = 3'b101
  } sep_dev_state_t;

  typedef enum logic [1:0] {
    K_SLAVE = 2'b00,
    K_HI    = 2'b01,
    K_LO    = 2'b10,
    K_DATA  = 2'b11
  } sep_rx_kind_t;

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0000,
    H_START  = 4'b0001,
    H_SLW    = 4'b0010,
    H_HI     = 4'b0011,
    H_LO     = 4'b0100,
    H_DATA   = 4'b0101,
    H_RSTART = 4'b0110,
    H_SLR    = 4'b0111,
    H_READ   = 4'b1000,
    H_STOP   = 4'b1001
  } sep_host_state_t;
endpackage

// >>> sep_if.sv
// two-wire link between the bus master and the eeprom, with wired-and resolution
`timescale 1ns/100ps
`default_nettype none
interface sep_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // pull-up: a line is low only while some end drives a low
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport host (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport dev (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// >>> sep_fifo.sv
// read data buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sep_fifo #(
  parameter int WIDTH = 8,                  // word width
  parameter int DEPTH = sep_pkg::FIFO_DEPTH // number of words
) (
  input  wire logic             clock,     // system clock
  input  wire logic             rst,       // synchronous reset
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word pushed
  output logic                  out_valid, // a word waits
  input  wire logic             out_ready, // consumer takes the word
  output logic [WIDTH-1:0]      out_data   // oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != FULL_CNT);
      out_valid <= (next_count != '0);
    end
  end
endmodule
`default_nettype wire

// >>> sep_host.sv
// bus master end: makes the serial clock, runs write, poll and read transfers
`timescale 1ns/100ps
`default_nettype none
module sep_host #(
  parameter int         QUARTER = sep_pkg::SCL_PERIOD_NS / (4 * sep_pkg::CLOCK_PERIOD_NS), // clocks per scl quarter
  parameter logic [3:0] DEV_ID  = sep_pkg::DEV_ID // identifier nibble
) (
  input  wire logic        clock,      // system clock
  input  wire logic        rst,        // synchronous reset
  input  wire logic        req_valid,  // request offered
  output logic             req_ready,  // idle, request taken
  input  wire logic        req_read,   // 1 read, 0 write
  input  wire logic        req_random, // read: set pointer first
  input  wire logic [15:0] req_addr,   // word address
  input  wire logic [7:0]  req_len,    // bytes to read
  input  wire logic [7:0]  req_wdata,  // byte to write
  input  wire logic [2:0]  req_sel,    // target select bits
  output logic             done,       // transfer ended pulse
  output logic             done_nack,  // a byte went unacknowledged
  output logic             rd_valid,   // read byte waiting
  input  wire logic        rd_ready,   // read byte taken
  output logic [7:0]       rd_data,    // read byte
  sep_if.host              bus         // two-wire link
);
  localparam int QW = $clog2(QUARTER + 1);
  localparam logic [QW-1:0] Q_LAST = QW'(QUARTER - 1);
  localparam logic [1:0] P0 = 2'h0;
  localparam logic [1:0] P1 = 2'h1;
  localparam logic [1:0] P2 = 2'h2;
  localparam logic [1:0] P3 = 2'h3;

  function automatic logic is_wbyte(input sep_pkg::sep_host_state_t s);
    return s == sep_pkg::H_SLW || s == sep_pkg::H_HI || s == sep_pkg::H_LO ||
           s == sep_pkg::H_DATA || s == sep_pkg::H_SLR;
  endfunction

  sep_pkg::sep_host_state_t state;
  logic [QW-1:0] qcnt;
  logic          tick;
  logic [1:0]    phase;
  logic [3:0]    bit_cnt;
  logic [7:0]    tx_sh;
  logic [7:0]    rx_sh;
  logic [7:0]    remaining;
  logic          is_read;
  logic          is_random;
  logic [15:0]   addr;
  logic [7:0]    wdata;
  logic [2:0]    sel;
  logic          ack_seen;
  logic          nack;
  logic          sda_meta;
  logic          sda_sync;
  logic          push;
  logic          fifo_in_ready;
  logic          stall;

  always_ff @(posedge clock) begin
    sda_meta <= bus.sda;
    sda_sync <= sda_meta;
  end

  // the scl divider; a stall holds scl low while the buffer is full
  always_ff @(posedge clock) begin
    if (rst) begin
      qcnt <= '0;
      tick <= 1'b0;
    end else if (qcnt == Q_LAST) begin
      qcnt <= '0;
      tick <= 1'b1;
    end else begin
      qcnt <= qcnt + 1'b1;
      tick <= 1'b0;
    end
  end

  assign stall = state == sep_pkg::H_READ && bit_cnt == '0 && phase == P0 && !fifo_in_ready;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= sep_pkg::H_IDLE;
      phase <= P0;
      bit_cnt <= '0;
      tx_sh <= '0;
      rx_sh <= '0;
      remaining <= '0;
      is_read <= 1'b0;
      is_random <= 1'b0;
      addr <= '0;
      wdata <= '0;
      sel <= '0;
      ack_seen <= 1'b0;
      nack <= 1'b0;
      push <= 1'b0;
      req_ready <= 1'b0;
      done <= 1'b0;
      done_nack <= 1'b0;
      bus.scl_m_o <= 1'b0;
      bus.scl_m_oe <= 1'b0;
      bus.sda_m_o <= 1'b0;
      bus.sda_m_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      push <= 1'b0;
      if (state == sep_pkg::H_IDLE) begin
        req_ready <= 1'b1;
        if (req_valid && req_ready) begin
          req_ready <= 1'b0;
          is_read <= req_read;
          is_random <= req_random;
          addr <= req_addr;
          wdata <= req_wdata;
          sel <= req_sel;
          remaining <= req_len;
          nack <= 1'b0;
          phase <= P0;
          state <= sep_pkg::H_START;
        end
      end else if (tick && !stall) begin
        phase <= phase + 2'h1;
        case (phase)
          P0: begin
            bus.scl_m_oe <= 1'b1;
            if (state == sep_pkg::H_START || state == sep_pkg::H_RSTART) begin
              bus.sda_m_oe <= 1'b0;
            end else if (state == sep_pkg::H_STOP) begin
              bus.sda_m_oe <= 1'b1;
            end else if (is_wbyte(state)) begin
              bus.sda_m_oe <= (bit_cnt != sep_pkg::BIT_ACK) && !tx_sh[7];
            end else begin
              // ack every byte but the last
              bus.sda_m_oe <= (bit_cnt == sep_pkg::BIT_ACK) && (remaining != 8'h01);
            end
          end
          P1: begin
            bus.scl_m_oe <= 1'b0;
          end
          P2: begin
            if (state == sep_pkg::H_START || state == sep_pkg::H_RSTART) begin
              bus.sda_m_oe <= 1'b1;
            end else if (state == sep_pkg::H_STOP) begin
              bus.sda_m_oe <= 1'b0;
            end else if (is_wbyte(state) && bit_cnt == sep_pkg::BIT_ACK) begin
              ack_seen <= !sda_sync;
            end else if (state == sep_pkg::H_READ && bit_cnt != sep_pkg::BIT_ACK) begin
              rx_sh <= {rx_sh[6:0], sda_sync};
            end
          end
          default: begin
            bit_cnt <= '0;
            if (state == sep_pkg::H_STOP) begin
              state <= sep_pkg::H_IDLE;
              done <= 1'b1;
              done_nack <= nack;
            end else if (state == sep_pkg::H_START || state == sep_pkg::H_RSTART) begin
              bus.scl_m_oe <= 1'b1;
              if (state == sep_pkg::H_RSTART || (is_read && !is_random)) begin
                tx_sh <= {DEV_ID, sel, sep_pkg::RW_READ};
                state <= sep_pkg::H_SLR;
              end else begin
                tx_sh <= {DEV_ID, sel, sep_pkg::RW_WRITE};
                state <= sep_pkg::H_SLW;
              end
            end else if (bit_cnt != sep_pkg::BIT_ACK) begin
              bus.scl_m_oe <= 1'b1;
              bit_cnt <= bit_cnt + 1'b1;
              tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
              bus.scl_m_oe <= 1'b1;
              if (state == sep_pkg::H_READ) begin
                push <= 1'b1;
                remaining <= remaining - 8'h01;
                if (remaining == 8'h01) begin
                  state <= sep_pkg::H_STOP;
                end
              end else if (!ack_seen) begin
                nack <= 1'b1;
                state <= sep_pkg::H_STOP;
              end else begin
                case (state)
                  sep_pkg::H_SLW: begin
                    tx_sh <= addr[15:8];
                    state <= sep_pkg::H_HI;
                  end
                  sep_pkg::H_HI: begin
                    tx_sh <= addr[7:0];
                    state <= sep_pkg::H_LO;
                  end
                  sep_pkg::H_LO: begin
                    tx_sh <= wdata;
                    state <= is_read ? sep_pkg::H_RSTART : sep_pkg::H_DATA;
                  end
                  sep_pkg::H_SLR: begin
                    state <= sep_pkg::H_READ;
                  end
                  default: begin
                    state <= sep_pkg::H_STOP;
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  sep_fifo #(
    .WIDTH (8),
    .DEPTH (sep_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sh),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule
`default_nettype wire

// >>> sep_link_properties.sv
// link-side timing and release checks of the eeprom end
`timescale 1ns/100ps
`default_nettype none
module sep_link_properties (
  input wire logic link_clk, // link sampling clock
  input wire logic rst,      // link-domain reset
  input wire logic scl,      // resolved clock line
  input wire logic sda,      // resolved data line
  input wire logic sda_s_o,  // device data level
  input wire logic sda_s_oe  // device pulls data low
);
  int low_cnt;

  // counts link clocks of scl low; saturates so a stalled clock cannot wrap it
  always_ff @(posedge link_clk) begin
    if (rst || scl) low_cnt <= 0;
    else if (low_cnt < 255) low_cnt <= low_cnt + 1;
  end

  default clocking @(posedge link_clk); endclocking
  default disable iff (rst);

  a_change_after_hold: assert property ($changed(sda_s_oe) |-> !scl && low_cnt >= 9)
    else $error("device data changed too soon after clock fall");
  a_drive_setup: assert property ($rose(sda_s_oe) |-> !scl [*3])
    else $error("device data driven too late before clock rise");
  a_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device data moved while clock high");
  a_stop_quiet: assert property (scl && $rose(sda) |-> ##1 !sda_s_oe [*8])
    else $error("device drove data after stop");
  a_start_quiet: assert property (scl && $fell(sda) |-> !sda_s_oe ##1 !sda_s_oe [*4])
    else $error("device drove data at start");
  a_open_drain: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drove data high");
  a_wired_low: assert property (sda_s_oe |-> !sda)
    else $error("data line high while device pulls low");
  a_reset_quiet: assert property ($fell(rst) |-> !sda_s_oe)
    else $error("device drove data out of reset");
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench: bus master end against eeprom end across the link
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic rd; logic rnd; logic wp; logic [2:0] sel; logic [15:0] addr; logic [7:0] len; logic [7:0] wd; logic nack;
  } sep_row_t;
  logic clock = 1'b0;
  logic rst, link_clk, link_rst, wp, req_valid, req_ready, req_read, req_random;
  logic done, done_nack, rd_valid, rd_ready, write_busy;
  logic [15:0] req_addr;
  logic [7:0] req_len, req_wdata, rd_data;
  logic [2:0] req_sel, sel_pins;
  int n_fail, compares;
  sep_row_t rows [6];

  sep_if sep_if_i ();
  // short quarter keeps the run bounded; device data still settles well inside scl low
  sep_host #(.QUARTER(100)) sep_host_i (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_random(req_random), .req_addr(req_addr), .req_len(req_len), .req_wdata(req_wdata),
    .req_sel(req_sel), .done(done), .done_nack(done_nack), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .bus(sep_if_i));
  // write cycle shortened so one poll sees busy and the next sees ready
  sep_device #(.WRITE_CYCLES(800)) sep_device_i (.link_clk(link_clk), .rst(link_rst), .wp(wp),
    .address_select_bit0(sel_pins[0]), .address_select_bit1(sel_pins[1]), .address_select_bit2(sel_pins[2]),
    .bus(sep_if_i), .write_busy(write_busy));
  sep_link_properties sep_link_properties_i (.link_clk(link_clk), .rst(link_rst), .scl(sep_if_i.scl),
    .sda(sep_if_i.sda), .sda_s_o(sep_if_i.sda_s_o), .sda_s_oe(sep_if_i.sda_s_oe));

  always #2 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_on(input int what);
    for (int n = 0; n < 100000; n++) begin
      @(negedge clock);
      case (what)
        0: if (req_ready === 1'b1) return;
        1: if (done === 1'b1) return;
        2: if (rd_valid === 1'b1) return;
        3: if (write_busy === 1'b0) return;
        default: if (write_busy === 1'b1) return;
      endcase
    end
    chk1(1'b1, 1'b0);
    summarize();
  endtask
  task automatic xfer(input sep_row_t r);
    wait_on(0);
    @(posedge clock);
    req_valid <= 1'b1;
    {req_read, req_random, wp, req_sel, req_addr, req_len, req_wdata} <= r[38:1];
    @(posedge clock);
    req_valid <= 1'b0;
    wait_on(1);
  endtask
  task automatic pop(input logic [7:0] exp);
    wait_on(2);
    chk8(rd_data, exp);
    @(posedge clock);
    rd_ready <= 1'b1;
    @(posedge clock);
    rd_ready <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    link_rst = 1'b1;
    {req_valid, req_read, req_random, wp, req_sel, req_addr, req_len, req_wdata, rd_ready} = '0;
    sel_pins = 3'h5;
    n_fail = 0;
    compares = 0;
    rows[0] = {3'b000, 3'h5, 16'h0000, 8'h01, 8'hc3, 1'b0};
    rows[1] = {3'b001, 3'h5, 16'h0000, 8'h01, 8'hff, 1'b1};
    rows[2] = {3'b100, 3'h2, 16'h0000, 8'h01, 8'h00, 1'b1};
    rows[3] = {3'b000, 3'h5, 16'h00ff, 8'h01, 8'h5a, 1'b0};
    rows[4] = {3'b110, 3'h5, 16'h00ff, 8'h02, 8'h00, 1'b0};
    rows[5] = {3'b100, 3'h5, 16'h0000, 8'h01, 8'h00, 1'b0};
    repeat (4) @(posedge link_clk);
    link_rst <= 1'b0;
    @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk1(write_busy, 1'b0);
    chk1(rd_valid, 1'b0);
    for (int k = 0; k < 3; k++) begin
      xfer(rows[k]);
      chk1(done_nack, rows[k].nack);
      if (rows[k].wp) begin
        repeat (200) @(negedge clock);
        chk1(write_busy, 1'b0);
      end else if (!rows[k].rd) begin
        wait_on(4);
        wait_on(3);
      end
    end
    // poll right after the write stop, bounded to a few tries
    xfer(rows[3]);
    chk1(done_nack, 1'b0);
    xfer(rows[5]);
    chk1(done_nack, 1'b1);
    for (int k = 0; k < 4 && done_nack !== 1'b0; k++) xfer(rows[5]);
    chk1(done_nack, rows[5].nack);
    // pointer wrapped past the top on the write, so the current read lands on 0
    pop(8'hc3);
    xfer(rows[4]);
    chk1(done_nack, 1'b0);
    pop(8'h5a);
    pop(8'hc3);
    summarize();
  end
endmodule
`default_nettype wire
